// File: tas_card_model.sv
// card-side model: makes one link clock period per frame of pins
// assumes the bench calls send; the core samples pins on link rises
`timescale 1ns/1ps
module tas_card_model (
  // link pins
  output logic link_clk,
  output tas_pkg::tas_link_t link_out
);
  initial begin
    link_clk = 1'b0;
    link_out = '0;
  end

  // link clock stands still between frames; pins turn over when idle
  task automatic send(input tas_pkg::tas_link_t v);
    link_out = v;
    #80;
    link_clk = 1'b1;
    #80;
    link_clk = 1'b0;
    // strobes turn over; block activity is a level and stays
    link_out = {~v[7:1], v.blk_active};
  endtask : send
endmodule : tas_card_model

// File: tas_link_capture.sv
// package of constants and types for transfer_activity_status, plus the
// link capture module that brings card-bus pins into the core clock domain.
// assumes link pins are valid around each rising edge of the link clock.
package tas_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  // register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_BLKCNT = 8'h08;
  localparam logic [7:0] OFS_INT_STS = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  // status register fields
  localparam int ST_READ_BUSY = 9;
  localparam int ST_WRITE_BUSY = 8;
  localparam int ST_RETRAIN = 3;
  // control register fields
  localparam int CT_GAP_HALT = 0;
  localparam int CT_RESUME = 1;
  localparam int CT_DESC_MODE = 2;
  localparam int CT_SAMP_TUNED = 3;
  localparam int CT_START_TRAIN = 4;
  // interrupt fields
  localparam int INT_W = 3;
  localparam int IR_XFER_DONE = 0;
  localparam int IR_GAP_PAUSE = 1;
  localparam int IR_RETRAIN = 2;
  // reset values
  localparam logic [CNT_W-1:0] BLKCNT_RST = 16'h0001;
  localparam logic [INT_W-1:0] INT_RST = 3'h0;
  localparam logic [INT_W-1:0] MASK_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;
  localparam int SYNC_STAGES = 2;

  // card-bus side pins, sampled on link clock rising edges
  typedef struct packed {
    logic rd_cmd_end;
    logic wr_cmd_end;
    logic rd_blk_end;
    logic wr_crc_sts;
    logic desc_end;
    logic drift;
    logic cmd_issue;
    logic blk_active;
  } tas_link_t;

  typedef enum logic [1:0] {
    DIR_IDLE = 2'b00,
    DIR_READ = 2'b01,
    DIR_WRITE = 2'b10
  } tas_dir_t;
endpackage : tas_pkg

`timescale 1ns/1ps
module tas_link_capture (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // raw link pins
  input wire logic link_clk,
  input wire tas_pkg::tas_link_t link_in,
  // captured pins
  output tas_pkg::tas_link_t evt,
  output logic evt_valid
);
  localparam int W = $bits(tas_pkg::tas_link_t) + 1;

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic clk_prev_r;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= {link_clk, link_in};
      sync_r <= meta_r;
    end
  end

  // rising edge of link clock found on synchronised copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_prev_r <= 1'b0;
      evt_valid <= 1'b0;
      evt <= '0;
    end else if (ce) begin
      clk_prev_r <= sync_r[W-1];
      evt_valid <= sync_r[W-1] & ~clk_prev_r;
      evt <= sync_r[W-2:0];
    end
  end
endmodule : tas_link_capture

// File: tas_top.sv
// transfer activity status: read/write busy flags, retraining request,
// event status with mask and one interrupt line.
// assumes a plain register port on CORE_CLK and card-bus pins on LINK_CLK.
// What this block does
// RULE_01 - read command end sets read busy
// RULE_02 - resume request restarts paused read busy
// RULE_03 - last block to system clears read
// RULE_04 - descriptor end clears read in descriptor mode
// RULE_05 - gap halt, buffer drained, idle clears read
// RULE_06 - read busy fall raises transfer done
// RULE_07 - write busy zero only without write data
// RULE_08 - write command end sets write busy
// RULE_09 - resume request restarts paused write busy
// RULE_10 - last block CRC status clears write
// RULE_11 - descriptor mode takes count from descriptors
// RULE_12 - CRC status under gap halt clears write
// RULE_13 - gap halt write fall raises pause
// RULE_14 - drift may set retraining request flag
// RULE_15 - training command clears retraining request
// RULE_16 - retraining rise raises retraining event
// RULE_17 - fixed sampling clock blocks retraining request
// RULE_18 - busy and retrain bits read only
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module tas_top #(
  parameter int CNT_W = tas_pkg::CNT_W
) (
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CE,
  // register port
  input wire logic [tas_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tas_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [tas_pkg::DATA_W-1:0] RDATA,
  // card-bus link
  input wire logic LINK_CLK,
  input wire tas_pkg::tas_link_t LINK_IN,
  // system side
  input wire logic SYS_BLK_DONE,
  // status and control outputs
  output logic READ_BUSY,
  output logic WRITE_BUSY,
  output logic RETRAIN_REQ,
  output logic GAP_HALT,
  output logic IRQ
);
  tas_pkg::tas_link_t evt;
  logic evt_valid;

  tas_link_capture u_cap (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .ce(CE),
    .link_clk(LINK_CLK),
    .link_in(LINK_IN),
    .evt(evt),
    .evt_valid(evt_valid)
  );

  // qualified link events, one cycle each
  logic e_rd_cmd;
  logic e_wr_cmd;
  logic e_rd_blk;
  logic e_wr_crc;
  logic e_desc;
  logic e_drift;
  logic e_cmd;
  assign e_rd_cmd = evt_valid & evt.rd_cmd_end;
  assign e_wr_cmd = evt_valid & evt.wr_cmd_end;
  assign e_rd_blk = evt_valid & evt.rd_blk_end;
  assign e_wr_crc = evt_valid & evt.wr_crc_sts;
  assign e_desc = evt_valid & evt.desc_end;
  assign e_drift = evt_valid & evt.drift;
  assign e_cmd = evt_valid & evt.cmd_issue;

  // register decode
  function automatic logic hit(input logic [tas_pkg::ADDR_W-1:0] a,
                               input logic [tas_pkg::ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_ctrl;
  logic wr_blkcnt;
  logic wr_int_sts;
  logic wr_int_mask;
  assign wr_ctrl = CE & WR & hit(ADDR, tas_pkg::OFS_CTRL);
  assign wr_blkcnt = CE & WR & hit(ADDR, tas_pkg::OFS_BLKCNT);
  assign wr_int_sts = CE & WR & hit(ADDR, tas_pkg::OFS_INT_STS);
  assign wr_int_mask = CE & WR & hit(ADDR, tas_pkg::OFS_INT_MASK);

  // control register
  logic gap_halt_r;
  logic desc_mode_r;
  logic samp_tuned_r;
  logic start_train_r;
  logic resume;
  assign resume = wr_ctrl & WDATA[tas_pkg::CT_RESUME];

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_halt_r <= 1'b0;
      desc_mode_r <= 1'b0;
      samp_tuned_r <= 1'b0;
      start_train_r <= 1'b0;
    end else if (wr_ctrl) begin
      gap_halt_r <= WDATA[tas_pkg::CT_GAP_HALT];
      desc_mode_r <= WDATA[tas_pkg::CT_DESC_MODE];
      samp_tuned_r <= WDATA[tas_pkg::CT_SAMP_TUNED];
      start_train_r <= WDATA[tas_pkg::CT_START_TRAIN];
    end
  end

  // programmed block count
  logic [CNT_W-1:0] blkcnt_r;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      blkcnt_r <= CNT_W'(tas_pkg::BLKCNT_RST);
    end else if (wr_blkcnt) begin
      blkcnt_r <= WDATA[CNT_W-1:0];
    end
  end

  // direction of the current or paused transfer
  tas_pkg::tas_dir_t dir_r;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dir_r <= tas_pkg::DIR_IDLE;
    end else if (CE) begin
      case (dir_r)
        tas_pkg::DIR_IDLE,
        tas_pkg::DIR_READ,
        tas_pkg::DIR_WRITE: begin
          if (e_rd_cmd) begin
            dir_r <= tas_pkg::DIR_READ;
          end else if (e_wr_cmd) begin
            dir_r <= tas_pkg::DIR_WRITE;
          end
        end
        default: dir_r <= tas_pkg::DIR_IDLE;
      endcase
    end
  end

  // descriptor table has marked the end of the transfer
  logic desc_last_r;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      desc_last_r <= 1'b0;
    end else if (CE) begin
      if (e_rd_cmd | e_wr_cmd) begin
        desc_last_r <= 1'b0;
      end else if (e_desc) begin
        desc_last_r <= 1'b1;
      end
    end
  end

  // read block counters: received from card, delivered to system
  logic [CNT_W-1:0] rd_rcv_r;
  logic [CNT_W-1:0] rd_sys_r;
  logic [CNT_W-1:0] rd_pend;
  logic sys_done;
  assign sys_done = CE & SYS_BLK_DONE;
  assign rd_pend = rd_rcv_r - rd_sys_r;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_rcv_r <= '0;
      rd_sys_r <= '0;
    end else if (CE) begin
      if (e_rd_cmd) begin
        rd_rcv_r <= '0;
        rd_sys_r <= '0;
      end else begin
        if (e_rd_blk) begin
          rd_rcv_r <= rd_rcv_r + CNT_W'(1);
        end
        if (sys_done) begin
          rd_sys_r <= rd_sys_r + CNT_W'(1);
        end
      end
    end
  end

  // read busy
  logic rd_busy_r;
  logic rd_busy_nxt;
  logic rd_last_blk;
  logic rd_desc_end;
  logic rd_gap_stop;
  assign rd_last_blk = sys_done & ~desc_mode_r
                     & (rd_sys_r + CNT_W'(1) == blkcnt_r); // RULE_03
  assign rd_desc_end = sys_done & desc_mode_r & desc_last_r
                     & (rd_pend == CNT_W'(1)) & ~evt.blk_active; // RULE_04
  assign rd_gap_stop = gap_halt_r & (rd_pend == '0) & ~sys_done
                     & ~evt.blk_active; // RULE_05

  always_comb begin
    rd_busy_nxt = rd_busy_r;
    if (rd_last_blk | rd_desc_end | rd_gap_stop) begin
      rd_busy_nxt = 1'b0;
    end
    if (e_rd_cmd) begin
      rd_busy_nxt = 1'b1; // RULE_01
    end else if (resume & (dir_r == tas_pkg::DIR_READ)) begin
      rd_busy_nxt = 1'b1; // RULE_02
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_busy_r <= 1'b0;
    end else if (CE) begin
      rd_busy_r <= rd_busy_nxt;
    end
  end

  // write: count CRC statuses against the programmed count
  logic [CNT_W-1:0] wr_crc_r;
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_crc_r <= '0;
    end else if (CE) begin
      if (e_wr_cmd) begin
        wr_crc_r <= '0;
      end else if (e_wr_crc) begin
        wr_crc_r <= wr_crc_r + CNT_W'(1);
      end
    end
  end

  // write busy
  logic wr_busy_r;
  logic wr_busy_nxt;
  logic wr_last_blk;
  logic wr_gap_stop;
  always_comb begin
    if (desc_mode_r) begin
      wr_last_blk = e_wr_crc & desc_last_r; // RULE_11
    end else begin
      wr_last_blk = e_wr_crc & (wr_crc_r + CNT_W'(1) == blkcnt_r); // RULE_10
    end
  end
  assign wr_gap_stop = e_wr_crc & gap_halt_r & ~wr_last_blk; // RULE_12

  always_comb begin
    wr_busy_nxt = wr_busy_r;
    // held data only ends at the final or halted CRC status
    if (wr_last_blk | wr_gap_stop) begin
      wr_busy_nxt = 1'b0; // RULE_07
    end
    if (e_wr_cmd) begin
      wr_busy_nxt = 1'b1; // RULE_08
    end else if (resume & (dir_r == tas_pkg::DIR_WRITE)) begin
      wr_busy_nxt = 1'b1; // RULE_09
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_busy_r <= 1'b0;
    end else if (CE) begin
      wr_busy_r <= wr_busy_nxt;
    end
  end

  // retraining request flag
  logic retrain_r;
  logic retrain_nxt;
  always_comb begin
    retrain_nxt = retrain_r;
    if (e_cmd & start_train_r) begin
      retrain_nxt = 1'b0; // RULE_15
    end else if (e_drift & samp_tuned_r) begin
      retrain_nxt = 1'b1; // RULE_14 RULE_17
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      retrain_r <= 1'b0;
    end else if (CE) begin
      retrain_r <= retrain_nxt;
    end
  end

  // event sources
  logic [tas_pkg::INT_W-1:0] int_set;
  always_comb begin
    int_set = '0;
    int_set[tas_pkg::IR_XFER_DONE] = (rd_busy_r & ~rd_busy_nxt) // RULE_06
      | (wr_busy_r & ~wr_busy_nxt & ~wr_gap_stop);
    int_set[tas_pkg::IR_GAP_PAUSE] = wr_busy_r & ~wr_busy_nxt
      & wr_gap_stop; // RULE_13
    int_set[tas_pkg::IR_RETRAIN] = ~retrain_r & retrain_nxt; // RULE_16
  end

  // sticky status, write one to clear, set wins
  logic [tas_pkg::INT_W-1:0] int_sts_r;
  logic [tas_pkg::INT_W-1:0] int_mask_r;
  logic [tas_pkg::INT_W-1:0] int_clr;
  assign int_clr = wr_int_sts ? WDATA[tas_pkg::INT_W-1:0] : '0;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_sts_r <= tas_pkg::INT_RST;
    end else if (CE) begin
      int_sts_r <= (int_sts_r & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_mask_r <= tas_pkg::MASK_RST;
    end else if (wr_int_mask) begin
      int_mask_r <= WDATA[tas_pkg::INT_W-1:0];
    end
  end

  // read mux; status bits read only, reserved bits zero
  logic [tas_pkg::DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = tas_pkg::RDATA_IDLE;
    case (ADDR)
      tas_pkg::OFS_STATUS: begin
        rd_mux[tas_pkg::ST_READ_BUSY] = rd_busy_r; // RULE_18
        rd_mux[tas_pkg::ST_WRITE_BUSY] = wr_busy_r;
        rd_mux[tas_pkg::ST_RETRAIN] = retrain_r;
      end
      tas_pkg::OFS_CTRL: begin
        rd_mux[tas_pkg::CT_GAP_HALT] = gap_halt_r;
        rd_mux[tas_pkg::CT_DESC_MODE] = desc_mode_r;
        rd_mux[tas_pkg::CT_SAMP_TUNED] = samp_tuned_r;
        rd_mux[tas_pkg::CT_START_TRAIN] = start_train_r;
      end
      tas_pkg::OFS_BLKCNT: rd_mux[CNT_W-1:0] = blkcnt_r;
      tas_pkg::OFS_INT_STS: rd_mux[tas_pkg::INT_W-1:0] = int_sts_r;
      tas_pkg::OFS_INT_MASK: rd_mux[tas_pkg::INT_W-1:0] = int_mask_r;
      default: rd_mux = tas_pkg::RDATA_IDLE;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= tas_pkg::RDATA_IDLE;
    end else if (CE) begin
      RDATA <= RD ? rd_mux : tas_pkg::RDATA_IDLE;
    end
  end

  // registered outputs
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      READ_BUSY <= 1'b0;
      WRITE_BUSY <= 1'b0;
      RETRAIN_REQ <= 1'b0;
      GAP_HALT <= 1'b0;
      IRQ <= 1'b0;
    end else if (CE) begin
      READ_BUSY <= rd_busy_nxt;
      WRITE_BUSY <= wr_busy_nxt;
      RETRAIN_REQ <= retrain_nxt;
      GAP_HALT <= gap_halt_r;
      IRQ <= |(((int_sts_r & ~int_clr) | int_set) & int_mask_r);
    end
  end
endmodule : tas_top

// File: tas_top_properties.sv
// assertions on the ports of tas_top
// assumes CE held high and a register port with one-cycle read latency
`timescale 1ns/1ps
module tas_top_properties #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic CE,
  // register port
  input wire logic [tas_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tas_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [tas_pkg::DATA_W-1:0] RDATA,
  // flags
  input wire logic READ_BUSY,
  input wire logic WRITE_BUSY,
  input wire logic RETRAIN_REQ,
  input wire logic GAP_HALT,
  input wire logic IRQ
);
  logic [2:0] mask_r;
  logic tuned_r;
  logic gap_r;
  logic seen_r;
  wire ctl_wr = CE && WR && ADDR == tas_pkg::OFS_CTRL;
  wire msk_wr = CE && WR && ADDR == tas_pkg::OFS_INT_MASK;

  // shadow of the control and mask fields seen on the port
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      mask_r <= '0;
      tuned_r <= 1'b0;
      gap_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      if (msk_wr)
        mask_r <= WDATA[2:0];
      if (ctl_wr)
        tuned_r <= WDATA[tas_pkg::CT_SAMP_TUNED];
      if (ctl_wr)
        gap_r <= WDATA[tas_pkg::CT_GAP_HALT];
      if (READ_BUSY || WRITE_BUSY)
        seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  chk_rdata_idle: assert property ($past(CE) && !$past(RD) |-> RDATA == '0)
    else $error("read data not idle");
  chk_status_view: assert property ($past(RD && ADDR == 8'h00) |->
    RDATA == {22'h0, $past(READ_BUSY), $past(WRITE_BUSY), 4'h0,
    $past(RETRAIN_REQ), 3'h0})
    else $error("status word wrong");
  chk_gap_copy: assert property (ctl_wr ##1 !ctl_wr |=> GAP_HALT == gap_r)
    else $error("gap halt copy wrong");
  chk_resume_sets: assert property (ctl_wr && WDATA[1] && seen_r |->
    ##[1:2] (READ_BUSY || WRITE_BUSY))
    else $error("resume did not restart");
  chk_fixed_clock: assert property ($rose(RETRAIN_REQ) |-> tuned_r || $past(tuned_r))
    else $error("retrain set on fixed clock");
  chk_read_done: assert property ($fell(READ_BUSY) && mask_r[0] |-> ##[0:1] IRQ)
    else $error("no irq on read end");
  chk_write_fall: assert property ($fell(WRITE_BUSY) && &mask_r[1:0] |-> ##[0:1] IRQ)
    else $error("no irq on write end");
  chk_retrain_irq: assert property ($rose(RETRAIN_REQ) && mask_r[2] |-> ##[0:1] IRQ)
    else $error("no irq on retrain");
  chk_mask_off: assert property (msk_wr && WDATA[2:0] == '0 ##1 !msk_wr |=> !IRQ)
    else $error("irq high with mask off");

  cover property ($fell(WRITE_BUSY));
  cover property ($fell(READ_BUSY));
  cover property ($rose(RETRAIN_REQ));
endmodule : tas_top_properties

bind tas_top tas_top_properties #(.CNT_W(CNT_W)) i_tas_top_properties (
  .CORE_CLK(CORE_CLK), .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .READ_BUSY(READ_BUSY),
  .WRITE_BUSY(WRITE_BUSY), .RETRAIN_REQ(RETRAIN_REQ), .GAP_HALT(GAP_HALT),
  .IRQ(IRQ)
);

// File: transfer_activity_status_bench.sv
// self-checking bench for tas_top with a card model on the link
// assumes CE tied high and the register map of tas_pkg
`timescale 1ns/1ps
module transfer_activity_status_bench;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } tas_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sys_done = 1'b0;
  logic [31:0] rdata;
  logic rbusy, wbusy, rtr, gap, irq, link_clk;
  tas_pkg::tas_link_t link;
  int error_cnt = 0;
  int samples_checked = 0;
  tas_row_t rows [8] = '{
    '{8'h04, 32'hffff_ffff, 32'h0000_001d}, '{8'h04, 32'h0, 32'h0},
    '{8'h08, 32'hffff_ffff, 32'h0000_ffff}, '{8'h10, 32'hffff_ffff, 32'h7},
    '{8'h00, 32'hffff_ffff, 32'h0}, '{8'h14, 32'hffff_ffff, 32'h0},
    '{8'h0c, 32'h7, 32'h0}, '{8'h08, 32'h2, 32'h2}};

  always #5 clk = ~clk;

  tas_top i_tas_top (
    .CORE_CLK(clk), .RST_B(rst_b), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LINK_CLK(link_clk), .LINK_IN(link),
    .SYS_BLK_DONE(sys_done), .READ_BUSY(rbusy), .WRITE_BUSY(wbusy),
    .RETRAIN_REQ(rtr), .GAP_HALT(gap), .IRQ(irq));
  tas_card_model i_tas_card_model (.link_clk(link_clk), .link_out(link));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rreg

  task automatic ev(input logic [7:0] v);
    i_tas_card_model.send(v);
  endtask : ev

  task automatic sys();
    @(posedge clk);
    sys_done <= 1'b1;
    @(posedge clk);
    sys_done <= 1'b0;
  endtask : sys

  // read busy, write busy, retrain, irq
  task automatic fl(input logic [3:0] e);
    repeat (2) @(posedge clk);
    #1;
    chk("flags", {28'h0, e}, {28'h0, rbusy, wbusy, rtr, irq});
  endtask : fl

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #500000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    chk("outs", 32'h0, {27'h0, rbusy, wbusy, rtr, gap, irq});
    rst_b <= 1'b1;
    rreg(8'h08, 32'h1);
    rreg(8'h0c, 32'h0);
    rreg(8'h10, 32'h0);
    rreg(8'h00, 32'h0);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, rows[i].e);
    end
    // two-block write, then two-block read
    ev(8'h40);
    fl(4'b0100);
    ev(8'h10);
    fl(4'b0100);
    ev(8'h10);
    fl(4'b0001);
    rreg(8'h0c, 32'h1);
    wreg(8'h0c, 32'h1);
    fl(4'b0000);
    ev(8'h80);
    fl(4'b1000);
    ev(8'h20);
    ev(8'h20);
    sys();
    fl(4'b1000);
    sys();
    fl(4'b0001);
    rreg(8'h0c, 32'h1);
    wreg(8'h0c, 32'h1);
    // write halted at a gap, then resumed
    ev(8'h40);
    wreg(8'h04, 32'h1);
    ev(8'h10);
    fl(4'b0001);
    chk("gap", 32'h1, {31'h0, gap});
    rreg(8'h0c, 32'h2);
    wreg(8'h04, 32'h2);
    fl(4'b0101);
    ev(8'h10);
    fl(4'b0001);
    rreg(8'h0c, 32'h3);
    wreg(8'h0c, 32'h7);
    // read halted at a gap, resumed, ended by descriptors
    wreg(8'h08, 32'h5);
    ev(8'h80);
    ev(8'h20);
    wreg(8'h04, 32'h1);
    fl(4'b1000);
    // a block still moving on the card bus holds the halt off
    ev(8'h01);
    sys();
    fl(4'b1000);
    ev(8'h00);
    fl(4'b0001);
    wreg(8'h0c, 32'h7);
    wreg(8'h04, 32'h2);
    fl(4'b1000);
    wreg(8'h04, 32'h4);
    ev(8'h08);
    ev(8'h20);
    sys();
    fl(4'b0001);
    wreg(8'h0c, 32'h7);
    ev(8'h40);
    ev(8'h10);
    fl(4'b0100);
    ev(8'h08);
    ev(8'h10);
    fl(4'b0001);
    wreg(8'h0c, 32'h7);
    wreg(8'h04, 32'h0);
    // retraining request
    ev(8'h04);
    fl(4'b0000);
    wreg(8'h04, 32'h8);
    ev(8'h04);
    fl(4'b0011);
    rreg(8'h00, 32'h8);
    wreg(8'h00, 32'hffff_ffff);
    rreg(8'h00, 32'h8);
    rreg(8'h0c, 32'h4);
    wreg(8'h10, 32'h0);
    fl(4'b0010);
    wreg(8'h10, 32'h4);
    fl(4'b0011);
    wreg(8'h0c, 32'h4);
    fl(4'b0010);
    wreg(8'h04, 32'h18);
    ev(8'h02);
    fl(4'b0000);
    // reset in mid-transfer
    ev(8'h80);
    fl(4'b1000);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("outs", 32'h0, {27'h0, rbusy, wbusy, rtr, gap, irq});
    rst_b <= 1'b1;
    rreg(8'h08, 32'h1);
    rreg(8'h00, 32'h0);
    print_verdict();
  end
endmodule : transfer_activity_status_bench
